// file: src/adcsm_params.svh
// Offsets, field positions, reset values and codes for the single-mode control
`ifndef ADCSM_PARAMS_SVH
`define ADCSM_PARAMS_SVH

// Register indices as printed; byte address is four times the index
`define ADCSM_IDX_CTRL0 32'h00800080
`define ADCSM_IDX_CTRL1 32'h00800081
`define ADCSM_ADDR_CTRL0 (`ADCSM_IDX_CTRL0 * 32'h4)
`define ADCSM_ADDR_CTRL1 (`ADCSM_IDX_CTRL1 * 32'h4)

// Bit D(n) of a byte sits at bit (7 - n mod 8): D0 is the MSB
`define ADCSM_POS_HW_SRC 5
`define ADCSM_POS_TRIG_SEL 4
`define ADCSM_POS_REQ_SEL 3
`define ADCSM_POS_COMPLETE 2
`define ADCSM_POS_STOP 1
`define ADCSM_POS_START 0

`define ADCSM_POS_MODE 7
`define ADCSM_POS_RATE 6
`define ADCSM_POS_ENH 5
`define ADCSM_POS_CH_HI 3
`define ADCSM_POS_CH_LO 0

`define ADCSM_RST_CTRL0 8'h04
`define ADCSM_RST_CTRL1 8'h00

// Writable bits of each byte; unassigned bits stay zero
`define ADCSM_WMASK_CTRL0 8'h38
`define ADCSM_WMASK_CTRL1 8'hEF

`define ADCSM_ENH_CHANNEL 4'hF
`define ADCSM_RESP_OKAY 2'h0
`define ADCSM_RESP_SLVERR 2'h2

`endif

// file: src/adcsm_pkg.sv
// Types shared by the single-mode control block
package adcsm_pkg;

  typedef enum logic [1:0] {
    ADCSM_IDLE = 2'b00,
    ADCSM_RUN = 2'b01,
    ADCSM_PRE = 2'b11
  } adcsm_state_type;

  // Conversion set-up handed to the converter core
  typedef struct packed {
    logic [3:0] channel;
    logic compare_mode;
    logic double_rate;
    logic enhance;
  } adcsm_cmd_type;

  // Result routing at completion
  typedef struct packed {
    logic to_data_reg;
    logic to_cmp_reg;
    logic [3:0] index;
  } adcsm_store_type;

endpackage

// file: src/adcsm_ctrl.sv
// Single-mode converter control with an AXI4-Lite register slave
//
// Summary of operation
// - Hardware source: pin when 0, timer event when 1
// - Software trigger ignores the hardware source bit
// - Pin held low after completion starts nothing
// - Trigger select: 0 software start, 1 hardware
// - Completion raises interrupt or DMA request per select
// - Complete flag read-only, 1 at reset, 0 while running
// - Forced stop also sets the complete flag
// - Stop halts a running single; ignored otherwise
// - After stop, partial value held, not stored
// - Start and stop together: stop wins
// - Stop during pre-empting single resumes the scan
// - Start while running restarts the single conversion
// - Start during scan cancels channel, later resumes
// - Mode bit: 0 conversion, 1 comparator
// - Rate bit: 0 normal, 1 double rate
// - Channel field D12-D15 selects inputs 0-15
// - Enhancement bit enables the enhancement function
// - Unassigned bits read zero, ignore writes
// - Registers also govern the pre-empting single
// - Enhancement forces input 15; D14, D15 drive pins
// - Comparator results go to the comparator register
`timescale 1ns/10ps
`include "adcsm_params.svh"

module adcsm_ctrl
  import adcsm_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ext_trigger_n,
  input wire logic timer_event3,
  input wire logic conv_done,
  input wire logic scan_active,
  output adcsm_cmd_type conv_cmd,
  output logic conv_start,
  output logic conv_abort,
  output logic sar_hold,
  output adcsm_store_type result_store,
  output logic irq_req,
  output logic dma_req,
  output logic scan_cancel,
  output logic scan_resume,
  output logic [1:0] selector_pins
);

  adcsm_state_type state;
  logic [7:0] ctrl0;
  logic [7:0] ctrl1;
  logic single_complete_flag;
  logic [31:0] aw_addr;
  logic [7:0] w_byte;
  logic w_lane0;
  logic aw_full;
  logic w_full;
  logic trig_sync1;
  logic trig_sync2;
  logic trig_prev;
  logic do_write;
  logic wr_ctrl0;
  logic wr_ctrl1;
  logic sw_start;
  logic sw_stop;
  logic hw_trig;
  logic go;
  logic running;
  adcsm_cmd_type next_cmd;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  function automatic logic addr_hit(input logic [31:0] a);
    addr_hit = (a == `ADCSM_ADDR_CTRL0) || (a == `ADCSM_ADDR_CTRL1);
  endfunction

  // Write channel: address and data may arrive in either order
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      s_axi_awready <= 1'b1;
      aw_full <= 1'b0;
      aw_addr <= 32'h0;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      s_axi_awready <= 1'b0;
      aw_full <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end
    else if (do_write)
      aw_full <= 1'b0;
    else if (s_axi_bvalid && s_axi_bready)
      s_axi_awready <= 1'b1;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      s_axi_wready <= 1'b1;
      w_full <= 1'b0;
      w_byte <= 8'h00;
      w_lane0 <= 1'b0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      s_axi_wready <= 1'b0;
      w_full <= 1'b1;
      w_byte <= s_axi_wdata[7:0];
      w_lane0 <= s_axi_wstrb[0];
    end
    else if (do_write)
      w_full <= 1'b0;
    else if (s_axi_bvalid && s_axi_bready)
      s_axi_wready <= 1'b1;
  end

  assign do_write = aw_full && w_full && !s_axi_bvalid;
  assign wr_ctrl0 = do_write && w_lane0 && aw_addr == `ADCSM_ADDR_CTRL0;
  assign wr_ctrl1 = do_write && w_lane0 && aw_addr == `ADCSM_ADDR_CTRL1;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `ADCSM_RESP_OKAY;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= addr_hit(aw_addr) ? `ADCSM_RESP_OKAY
                                       : `ADCSM_RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // Read channel; start and stop always read back as zero
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `ADCSM_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= addr_hit(s_axi_araddr) ? `ADCSM_RESP_OKAY
                                            : `ADCSM_RESP_SLVERR;
      if (s_axi_araddr == `ADCSM_ADDR_CTRL0)
        s_axi_rdata <= {24'h0, ctrl0};
      else if (s_axi_araddr == `ADCSM_ADDR_CTRL1)
        s_axi_rdata <= {24'h0, ctrl1};
      else
        s_axi_rdata <= 32'h0;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Stored control bits; complete flag and unassigned bits not writable
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      ctrl0 <= `ADCSM_RST_CTRL0;
      ctrl1 <= `ADCSM_RST_CTRL1;
    end
    else
    begin
      ctrl0 <= (w_byte & `ADCSM_WMASK_CTRL0 & {8{wr_ctrl0}})
             | (ctrl0 & ~(`ADCSM_WMASK_CTRL0 & {8{wr_ctrl0}})
                & ~(8'h01 << `ADCSM_POS_COMPLETE))
             | ({7'h00, single_complete_flag} << `ADCSM_POS_COMPLETE);
      if (wr_ctrl1)
        ctrl1 <= w_byte & `ADCSM_WMASK_CTRL1;
    end
  end

  // Pin is asynchronous; only the second stage feeds the edge detect
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      trig_sync1 <= 1'b1;
      trig_sync2 <= 1'b1;
      trig_prev <= 1'b1;
    end
    else
    begin
      trig_sync1 <= ext_trigger_n;
      trig_sync2 <= trig_sync1;
      trig_prev <= trig_sync2;
    end
  end

  // Falling edge only, so a pin left low cannot re-trigger
  assign hw_trig = ctrl0[`ADCSM_POS_TRIG_SEL]
                && (ctrl0[`ADCSM_POS_HW_SRC] ? timer_event3
                    : (trig_prev && !trig_sync2));
  assign sw_start = wr_ctrl0 && w_byte[`ADCSM_POS_START]
                 && !ctrl0[`ADCSM_POS_TRIG_SEL];
  assign sw_stop = wr_ctrl0 && w_byte[`ADCSM_POS_STOP];
  assign go = (sw_start || hw_trig) && !sw_stop;
  assign running = state != ADCSM_IDLE;

  // Set-up for the next conversion, taken fresh at every start
  always_comb
  begin
    next_cmd.compare_mode = ctrl1[`ADCSM_POS_MODE];
    next_cmd.double_rate = ctrl1[`ADCSM_POS_RATE];
    next_cmd.enhance = ctrl1[`ADCSM_POS_ENH];
    next_cmd.channel = ctrl1[`ADCSM_POS_ENH] ? `ADCSM_ENH_CHANNEL
      : ctrl1[`ADCSM_POS_CH_HI:`ADCSM_POS_CH_LO];
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      conv_cmd <= '0;
    else if (go)
      conv_cmd <= next_cmd;
  end

  // D14 on pin 0, D15 on pin 1, only while enhancement is on
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      selector_pins <= 2'b00;
    else if (ctrl1[`ADCSM_POS_ENH])
      selector_pins <= {ctrl1[0], ctrl1[1]};
    else
      selector_pins <= 2'b00;
  end

  // Sequencer; stop outranks start and completion in the same cycle
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      state <= ADCSM_IDLE;
      single_complete_flag <= 1'b1;
      conv_start <= 1'b0;
      conv_abort <= 1'b0;
      sar_hold <= 1'b0;
      scan_cancel <= 1'b0;
      scan_resume <= 1'b0;
      irq_req <= 1'b0;
      dma_req <= 1'b0;
      result_store <= '0;
    end
    else
    begin
      conv_start <= 1'b0;
      conv_abort <= 1'b0;
      scan_cancel <= 1'b0;
      scan_resume <= 1'b0;
      irq_req <= 1'b0;
      dma_req <= 1'b0;
      result_store <= '0;
      case (state)
        ADCSM_IDLE:
          if (go)
          begin
            conv_start <= 1'b1;
            sar_hold <= 1'b0;
            single_complete_flag <= 1'b0;
            if (scan_active)
            begin
              scan_cancel <= 1'b1;
              state <= ADCSM_PRE;
            end
            else
              state <= ADCSM_RUN;
          end
        ADCSM_RUN, ADCSM_PRE:
          if (sw_stop)
          begin
            conv_abort <= 1'b1;
            sar_hold <= 1'b1;
            single_complete_flag <= 1'b1;
            scan_resume <= state == ADCSM_PRE;
            state <= ADCSM_IDLE;
          end
          else if (go)
          begin
            conv_abort <= 1'b1;
            conv_start <= 1'b1;
          end
          else if (conv_done)
          begin
            single_complete_flag <= 1'b1;
            result_store.to_data_reg <= !conv_cmd.compare_mode;
            result_store.to_cmp_reg <= conv_cmd.compare_mode;
            result_store.index <= conv_cmd.channel;
            irq_req <= !ctrl0[`ADCSM_POS_REQ_SEL];
            dma_req <= ctrl0[`ADCSM_POS_REQ_SEL];
            scan_resume <= state == ADCSM_PRE;
            state <= ADCSM_IDLE;
          end
        default:
          state <= ADCSM_IDLE;
      endcase
    end
  end

  chk_stop_wins: assert property (running && sw_stop |=>
    !conv_start && conv_abort && state == ADCSM_IDLE)
    else $error("stop with start did not halt");

  chk_flag_clears: assert property (!running && go |=>
    !single_complete_flag ##1 !ctrl0[`ADCSM_POS_COMPLETE])
    else $error("complete flag not cleared on start");

  chk_stop_sets_flag: assert property (running && sw_stop |=>
    single_complete_flag ##1 ctrl0[`ADCSM_POS_COMPLETE])
    else $error("complete flag not set on stop");

  chk_stop_idle: assert property (!running && sw_stop && !go |=>
    !conv_abort && state == ADCSM_IDLE)
    else $error("stop acted while idle");

  chk_req_route: assert property (running && conv_done && !sw_stop
    && !go |=> (irq_req != dma_req)
    && dma_req == $past(ctrl0[`ADCSM_POS_REQ_SEL]))
    else $error("wrong completion request");

  chk_no_store_stop: assert property (running && sw_stop |=>
    !result_store.to_data_reg && !result_store.to_cmp_reg && sar_hold)
    else $error("stopped value was stored");

  chk_resume_pre: assert property (state == ADCSM_PRE && sw_stop
    |=> scan_resume ##1 !scan_resume)
    else $error("scan not resumed after stop");

  chk_restart: assert property (running && go && !sw_stop |=>
    conv_start && conv_abort && running)
    else $error("restart not issued");

  chk_cancel_scan: assert property (!running && go && scan_active
    |=> scan_cancel && state == ADCSM_PRE)
    else $error("scan not cancelled");

  chk_sw_ignores: assert property (!ctrl0[`ADCSM_POS_TRIG_SEL]
    && !sw_start && !running |=> !conv_start)
    else $error("hardware trigger acted under software select");

  chk_enh_channel: assert property (go && ctrl1[`ADCSM_POS_ENH]
    |=> conv_cmd.channel == `ADCSM_ENH_CHANNEL)
    else $error("enhancement did not force input 15");

  chk_reserved_zero: assert property ((ctrl0 & 8'hC3) == 8'h00
    && ctrl1[4] == 1'b0)
    else $error("unassigned bit not zero");

  cov_single_done: cover property (state == ADCSM_RUN && conv_done);
  cov_preempt: cover property (scan_cancel ##[1:50] scan_resume);
  cov_restart: cover property (running && go && !sw_stop);
  cov_pin_trigger: cover property (hw_trig && !ctrl0[`ADCSM_POS_HW_SRC]);

endmodule

// file: tb/adcsm_core_model.sv
// Behavioural converter core: fixed latency, abortable
`timescale 1ns/10ps

module adcsm_core_model
#(
  parameter int LAT = 12
)
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic conv_start,
  input wire logic conv_abort,
  output logic conv_done
);
  int cnt;

  // A restart reloads the count, so start outranks abort
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      cnt <= 0;
    else if (conv_start)
      cnt <= LAT;
    else if (conv_abort)
      cnt <= 0;
    else if (cnt != 0)
      cnt <= cnt - 1;
  end

  assign conv_done = (cnt == 1);
endmodule

// file: tb/tb_top.sv
// Register-level bench for the single-mode control block
`timescale 1ns/10ps
`include "adcsm_params.svh"

module tb_top;
  import adcsm_pkg::*;
  logic sys_clk, rst, awv, wv, bry, arv, rry, pin_n, tmr, scan;
  logic [31:0] awa, wd, ara, d;
  logic [1:0] r;
  logic awr, wr_rdy, bv, arr, rv, done, start, abort, hold, irq, dma;
  logic canc, res;
  logic [1:0] br, rr, sel;
  logic [31:0] rd_q;
  logic [1:0] b_q;
  adcsm_cmd_type cmd, cmd_q;
  adcsm_store_type st, st_q;
  int miscompares, checks, n_start, n_abort, n_irq, n_dma, n_store;
  int n_canc, n_res;
  localparam logic [31:0] A0 = `ADCSM_ADDR_CTRL0;
  localparam logic [31:0] A1 = `ADCSM_ADDR_CTRL1;

  adcsm_ctrl dut_u (.sys_clk(sys_clk), .rst(rst), .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr_rdy),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rd_q), .s_axi_rresp(rr), .s_axi_rvalid(rv),
    .s_axi_rready(rry), .ext_trigger_n(pin_n), .timer_event3(tmr),
    .conv_done(done), .scan_active(scan), .conv_cmd(cmd),
    .conv_start(start), .conv_abort(abort), .sar_hold(hold),
    .result_store(st), .irq_req(irq), .dma_req(dma),
    .scan_cancel(canc), .scan_resume(res), .selector_pins(sel));
  adcsm_core_model core_u (.sys_clk(sys_clk), .rst(rst),
    .conv_start(start), .conv_abort(abort), .conv_done(done));

  initial
  begin
    sys_clk = 0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // Pulse counters; cleared by the sequence on the falling edge
  always @(posedge sys_clk)
  begin
    n_start += start;
    n_abort += abort;
    n_irq += irq;
    n_dma += dma;
    n_canc += canc;
    n_res += res;
    if (start === 1'b1) cmd_q = cmd;
    if (st.to_data_reg | st.to_cmp_reg)
    begin
      st_q = st;
      n_store++;
    end
  end

  task clr;
    @(negedge sys_clk);
    {n_start, n_abort, n_irq, n_dma, n_canc, n_res, n_store} = '0;
  endtask

  task print_verdict;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task tmo(input bit ok);
    if (!ok)
    begin
      $display("[ERR] %0t wait expired", $time);
      miscompares++;
      print_verdict();
    end
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
      miscompares++;
    end
  endtask

  task wr(input logic [31:0] a, input logic [7:0] v);
    bit ad, wdn, ok;
    int i;
    @(posedge sys_clk);
    awa <= a;
    wd <= {24'h0, v};
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    ad = 0;
    wdn = 0;
    ok = 0;
    for (i = 0; i < 50 && !ok; i++)
    begin
      @(posedge sys_clk);
      if (ad && wdn && bv === 1'b1)
      begin
        ok = 1;
        b_q = br;
      end
      if (awv && awr === 1'b1) ad = 1;
      if (wv && wr_rdy === 1'b1) wdn = 1;
      if (ad) awv <= 1'b0;
      if (wdn) wv <= 1'b0;
    end
    tmo(ok);
    bry <= 1'b0;
  endtask

  task rd(input logic [31:0] a, output logic [31:0] v, output logic [1:0] e);
    bit ad, ok;
    int i;
    @(posedge sys_clk);
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    ad = 0;
    ok = 0;
    for (i = 0; i < 50 && !ok; i++)
    begin
      @(posedge sys_clk);
      if (ad && rv === 1'b1)
      begin
        ok = 1;
        v = rd_q;
        e = rr;
      end
      if (!ad && arr === 1'b1)
      begin
        ad = 1;
        arv <= 1'b0;
      end
    end
    tmo(ok);
    rry <= 1'b0;
  endtask

  // Waits for the completion request, then lets counters settle
  task wdone;
    int i;
    for (i = 0; i < 60 && !(irq === 1'b1 || dma === 1'b1); i++)
      @(posedge sys_clk);
    tmo(i < 60);
    @(negedge sys_clk);
  endtask

  task pulse_tmr;
    @(posedge sys_clk);
    tmr <= 1'b1;
    @(posedge sys_clk);
    tmr <= 1'b0;
    repeat (5) @(posedge sys_clk);
  endtask

  initial
  begin
    {awv, wv, bry, arv, rry, tmr, scan, awa, wd, ara} = '0;
    {miscompares, checks} = '0;
    pin_n = 1;
    rst = 1;
    repeat (8) @(posedge sys_clk);
    rst <= 0;
    rd(A0, d, r);
    chk(d, 32'h04);
    chk(r, `ADCSM_RESP_OKAY);
    rd(A1, d, r);
    chk(d, 32'h00);
    rd(32'h10, d, r);
    chk(r, `ADCSM_RESP_SLVERR);
    wr(32'h10, 8'hFF);
    chk(b_q, `ADCSM_RESP_SLVERR);
    wr(A1, 8'hFF);
    chk(b_q, `ADCSM_RESP_OKAY);
    rd(A1, d, r);
    chk(d, 32'hEF);
    chk(sel, 2'h3);
    wr(A0, 8'hFF);
    rd(A0, d, r);
    chk(d, 32'h3C);
    wr(A0, 8'h00);
    clr();
    wr(A0, 8'h03);
    repeat (5) @(posedge sys_clk);
    chk(n_start, 0);
    wr(A1, 8'h85);
    clr();
    wr(A0, 8'h01);
    rd(A0, d, r);
    chk(d, 32'h00);
    wdone();
    chk(cmd_q, {4'h5, 3'b100});
    chk(st_q, {2'b01, 4'h5});
    chk(n_irq, 1);
    rd(A0, d, r);
    chk(d, 32'h04);
    wr(A1, 8'h43);
    clr();
    wr(A0, 8'h09);
    wdone();
    chk(n_dma, 1);
    chk(n_irq, 0);
    chk(cmd_q, {4'h3, 3'b010});
    chk(st_q, {2'b10, 4'h3});
    clr();
    wr(A0, 8'h01);
    wr(A0, 8'h02);
    repeat (20) @(posedge sys_clk);
    rd(A0, d, r);
    chk(d, 32'h04);
    chk(hold, 1'b1);
    chk(n_store + n_irq, 0);
    chk(n_abort, 1);
    clr();
    wr(A0, 8'h01);
    wr(A0, 8'h01);
    wdone();
    chk(n_start, 2);
    chk(n_irq, 1);
    chk(hold, 1'b0);
    @(posedge sys_clk);
    scan <= 1'b1;
    clr();
    wr(A0, 8'h01);
    wdone();
    chk(n_canc, 1);
    chk(n_res, 1);
    chk(cmd_q, {4'h3, 3'b010});
    clr();
    wr(A0, 8'h01);
    wr(A0, 8'h02);
    repeat (20) @(posedge sys_clk);
    chk(n_res, 1);
    chk(n_store, 0);
    clr();
    wr(A0, 8'h02);
    repeat (5) @(posedge sys_clk);
    chk(n_abort + n_res, 0);
    scan <= 1'b0;
    wr(A0, 8'h30);
    clr();
    wr(A0, 8'h31);
    repeat (5) @(posedge sys_clk);
    chk(n_start, 0);
    pulse_tmr();
    wdone();
    chk(n_start, 1);
    wr(A0, 8'h20);
    clr();
    pulse_tmr();
    chk(n_start, 0);
    wr(A0, 8'h21);
    wdone();
    chk(n_start, 1);
    wr(A0, 8'h10);
    clr();
    @(posedge sys_clk);
    pin_n <= 1'b0;
    wdone();
    repeat (20) @(posedge sys_clk);
    chk(n_start, 1);
    pin_n <= 1'b1;
    wr(A0, 8'h00);
    wr(A1, 8'h22);
    // Pins update on the edge that ends the write; look after it settles
    clr();
    chk(sel, 2'h1);
    wr(A0, 8'h01);
    wdone();
    chk(cmd_q, {4'hF, 3'b001});
    chk(st_q, {2'b10, 4'hF});
    print_verdict();
  end
endmodule
